/* hdl/aas_pkg.sv */
`default_nettype none
package aas_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA0   = 8'h00; // 8 data words, 0x00..0x1C
    localparam logic [7:0] ADDR_LT6     = 8'h20;
    localparam logic [7:0] ADDR_LT7     = 8'h24;
    localparam logic [7:0] ADDR_UT6     = 8'h28;
    localparam logic [7:0] ADDR_UT7     = 8'h2C;
    localparam logic [7:0] ADDR_CTRL    = 8'h30;
    localparam logic [7:0] ADDR_CMPRES  = 8'h34;
    localparam logic [7:0] ADDR_INTCTL  = 8'h38;
    localparam logic [7:0] ADDR_PRESC   = 8'h3C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_CONT_BIT  = 1;
    localparam int CTRL_POW_BIT   = 2;
    localparam int CTRL_EXTEN_BIT = 3;
    localparam int CTRL_INTEN_BIT = 4;
    localparam int CTRL_FCH_LSB   = 5;
    localparam int INT_EOS_BIT    = 0;
    localparam int INT_WDG_BIT    = 1;
    localparam int INT_EOSM_BIT   = 2;
    localparam int INT_WDGM_BIT   = 3;
    localparam int INT_PRI_LSB    = 4;
    localparam int CMP_LSB        = 4;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [2:0]  PRESC_RESET     = 3'h7;
    localparam logic [7:0]  THR_LOW_RESET   = 8'h00;
    localparam logic [7:0]  THR_HIGH_RESET  = 8'hFF;
    localparam int          CONV_CYCLES     = 138;
    localparam int          SAMPLE_CYCLES   = 84;
    localparam logic [7:0]  CONV_CYC_8      = 8'(CONV_CYCLES);
    localparam logic [7:0]  SAMPLE_CYC_8    = 8'(SAMPLE_CYCLES);
    localparam logic [2:0]  LAST_CHANNEL    = 3'h7;
    localparam logic [2:0]  WDG_CH_A        = 3'h6;
    localparam logic [4:0]  FACTOR_MAX      = 5'h10;

    typedef struct packed {
        logic       valid;
        logic [2:0] channel;
        logic [7:0] value;
    } aas_result_s;

    typedef enum logic [2:0] {
        AAS_IDLE   = 3'b001,
        AAS_SAMPLE = 3'b010,
        AAS_CONV   = 3'b100
    } aas_state_e;

    // Division factor: 111 -> 1, 110 -> 2 ... 100 -> 8, lower codes (000..011) -> 16
    function automatic logic [4:0] aas_factor(input logic [2:0] sel);
        logic [4:0] f;
        f = 5'h00;
        unique case (sel)
            3'b111: f = 5'h01;
            3'b110: f = 5'h02;
            3'b101: f = 5'h04;
            3'b100: f = 5'h08;
            default: f = FACTOR_MAX;
        endcase
        return f;
    endfunction : aas_factor

endpackage : aas_pkg
`default_nettype wire

/* hdl/aas_timer.sv */
`default_nettype none
module aas_timer
    import aas_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       rstn_in,
    input  wire logic       start_in,
    input  wire logic       abort_in,
    input  wire logic [4:0] factor_in,
    output logic            sample_out,
    output logic            done_out
);
    // ------------------------------------------------------------
    // Prescale and cycle counters
    // ------------------------------------------------------------
    logic [4:0] pre_reg;
    logic [4:0] pre_next;
    logic [7:0] cyc_reg;
    logic [7:0] cyc_next;
    logic       busy_reg;
    logic       busy_next;
    logic       tick;
    logic       last;

    assign tick       = busy_reg && (pre_reg == factor_in - 5'h01);
    assign last       = tick && (cyc_reg == CONV_CYC_8 - 8'h01);
    assign pre_next   = (start_in || !busy_reg || tick) ? 5'h00 : pre_reg + 5'h01;
    assign cyc_next   = (start_in || !busy_reg) ? 8'h00 : (tick ? cyc_reg + 8'h01 : cyc_reg);
    assign busy_next  = abort_in ? 1'b0 : (start_in ? 1'b1 : (last ? 1'b0 : busy_reg));
    assign sample_out = busy_reg && (cyc_reg < SAMPLE_CYC_8);

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            pre_reg  <= 5'h00;
            cyc_reg  <= 8'h00;
            busy_reg <= 1'b0;
            done_out <= 1'b0;
        end else begin
            pre_reg  <= pre_next;
            cyc_reg  <= cyc_next;
            busy_reg <= busy_next;
            done_out <= last && !abort_in;
        end
    end
endmodule : aas_timer
`default_nettype wire

/* hdl/aas_watch.sv */
`default_nettype none
module aas_watch
    import aas_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rstn_in,
    input  wire aas_result_s result_in,
    input  wire logic [7:0]  low6_in,
    input  wire logic [7:0]  low7_in,
    input  wire logic [7:0]  high6_in,
    input  wire logic [7:0]  high7_in,
    input  wire logic        clear_in,
    output logic [3:0]       flags_out,
    output logic             alarm_out
);
    // ------------------------------------------------------------
    // Window compare on the two guarded channels
    // ------------------------------------------------------------
    logic       is6;
    logic       is7;
    logic [3:0] hit;
    logic [3:0] flags_next;

    assign is6 = result_in.valid && (result_in.channel == WDG_CH_A);
    assign is7 = result_in.valid && (result_in.channel == LAST_CHANNEL);
    // Bits: 0 low6, 1 high6, 2 low7, 3 high7
    assign hit[0] = is6 && (result_in.value <  low6_in);
    assign hit[1] = is6 && (result_in.value >= high6_in);
    assign hit[2] = is7 && (result_in.value <  low7_in);
    assign hit[3] = is7 && (result_in.value >= high7_in);
    // New hits win over a clear in the same cycle
    assign flags_next = (clear_in ? 4'h0 : flags_out) | hit;

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            flags_out <= 4'h0;
            alarm_out <= 1'b0;
        end else begin
            flags_out <= flags_next;
            alarm_out <= |hit;
        end
    end
endmodule : aas_watch
`default_nettype wire

/* hdl/aas_sequencer.sv */
`default_nettype none
module aas_sequencer
    import aas_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rstn_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_trigger_input_in,
    input  wire logic        timer_trigger_input_in,
    input  wire logic [7:0]  conv_value_in,
    output logic [2:0]       mux_channel_out,
    output logic             sample_hold_out,
    output logic             power_up_out,
    output logic             irq_out,
    output logic             irq_is_alarm_out,
    output logic [2:0]       irq_level_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    aas_state_e  state_reg;
    aas_state_e  state_next;
    logic [7:0]  data_reg [0:7];
    logic [7:0]  low6_reg;
    logic [7:0]  low7_reg;
    logic [7:0]  high6_reg;
    logic [7:0]  high7_reg;
    logic        conversion_running_flag;
    logic        repeat_mode_reg;
    logic        power_reg;
    logic        ext_en_reg;
    logic        tim_en_reg;
    logic [2:0]  first_channel_select;
    logic [2:0]  division_select;
    logic [2:0]  level_reg;
    logic        end_of_sequence_request;
    logic        window_alarm_request;
    logic        eos_mask_reg;
    logic        wdg_mask_reg;
    logic [2:0]  chan_reg;
    logic [2:0]  seq_first_reg;
    logic [4:0]  seq_factor_reg;
    logic        ext_prev_reg;
    logic        tim_prev_reg;
    logic [7:0]  sample_reg;
    aas_result_s result;
    logic [3:0]  cmp_flags;
    logic        alarm_hit;
    logic        conv_done;
    logic        conv_sample;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic        wr;
    logic        rd_ok;
    logic        sel_data;
    logic        wr_ctrl;
    logic        wr_int;
    logic        wdg_clear;
    logic [31:0] rd_mux;

    assign pready   = 1'b1;
    assign wr       = psel && penable && pwrite;
    assign sel_data = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
    assign wr_ctrl  = wr && (paddr == ADDR_CTRL);
    assign wr_int   = wr && (paddr == ADDR_INTCTL);
    assign rd_ok    = sel_data || (paddr == ADDR_LT6) || (paddr == ADDR_LT7)
                   || (paddr == ADDR_UT6) || (paddr == ADDR_UT7)
                   || (paddr == ADDR_CTRL) || (paddr == ADDR_CMPRES)
                   || (paddr == ADDR_INTCTL) || (paddr == ADDR_PRESC);
    assign pslverr  = psel && penable && !rd_ok;
    // Software clearing the alarm flag also clears the compare flags
    assign wdg_clear = wr_int && !pwdata[INT_WDG_BIT];

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_data) begin
            rd_mux = {24'h00_0000, data_reg[paddr[4:2]]};
        end else if (paddr == ADDR_LT6) begin
            rd_mux = {24'h00_0000, low6_reg};
        end else if (paddr == ADDR_LT7) begin
            rd_mux = {24'h00_0000, low7_reg};
        end else if (paddr == ADDR_UT6) begin
            rd_mux = {24'h00_0000, high6_reg};
        end else if (paddr == ADDR_UT7) begin
            rd_mux = {24'h00_0000, high7_reg};
        end else if (paddr == ADDR_CTRL) begin
            rd_mux = {24'h00_0000, first_channel_select, tim_en_reg, ext_en_reg,
                      power_reg, repeat_mode_reg, conversion_running_flag};
        end else if (paddr == ADDR_CMPRES) begin
            rd_mux = {24'h00_0000, cmp_flags, 4'h0};
        end else if (paddr == ADDR_INTCTL) begin
            rd_mux = {25'h000_0000, level_reg, wdg_mask_reg, eos_mask_reg,
                      window_alarm_request, end_of_sequence_request};
        end else if (paddr == ADDR_PRESC) begin
            rd_mux = {29'h0000_0000, division_select};
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Start detection and sequencing
    // ------------------------------------------------------------
    logic trig_edge;
    logic sw_start;
    logic start;
    logic last_done;
    logic seq_end;
    logic running_next;
    logic [2:0] fch_now;

    // A start written together with a new first channel uses the new one
    assign fch_now = wr_ctrl ? pwdata[CTRL_FCH_LSB +: 3] : first_channel_select;

    // Rising edges of enabled trigger inputs
    assign trig_edge = (ext_en_reg && external_trigger_input_in && !ext_prev_reg)
                    || (tim_en_reg && timer_trigger_input_in && !tim_prev_reg);
    assign sw_start  = wr_ctrl && pwdata[CTRL_RUN_BIT] && !conversion_running_flag;
    // Triggers only count while idle, which also covers continuous mode
    assign start     = power_reg && !conversion_running_flag && (sw_start || trig_edge);
    assign last_done = conv_done && (chan_reg == LAST_CHANNEL);
    assign seq_end   = last_done && !repeat_mode_reg;
    // Hardware clear in single mode; software clear of the flag stops continuous runs
    assign running_next = start ? 1'b1
                        : ((seq_end || !power_reg) ? 1'b0
                        : (wr_ctrl ? pwdata[CTRL_RUN_BIT] && conversion_running_flag
                        : conversion_running_flag));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            AAS_IDLE: begin
                if (start) begin
                    state_next = AAS_SAMPLE;
                end
            end
            AAS_SAMPLE: begin
                if (!running_next) begin
                    state_next = AAS_IDLE;
                end else if (!conv_sample) begin
                    state_next = AAS_CONV;
                end
            end
            AAS_CONV: begin
                if (!running_next) begin
                    state_next = AAS_IDLE;
                end else if (conv_done) begin
                    state_next = AAS_SAMPLE;
                end
            end
            default: state_next = AAS_IDLE;
        endcase
    end

    logic timer_start;
    logic abort;
    assign timer_start = start || (conv_done && running_next);
    assign abort       = (state_reg != AAS_IDLE) && !running_next;

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            state_reg               <= AAS_IDLE;
            conversion_running_flag <= 1'b0;
            chan_reg                <= 3'h0;
            seq_first_reg           <= 3'h0;
            seq_factor_reg          <= 5'h01;
            ext_prev_reg            <= 1'b0;
            tim_prev_reg            <= 1'b0;
            sample_reg              <= 8'h00;
        end else begin
            state_reg               <= state_next;
            conversion_running_flag <= running_next;
            ext_prev_reg            <= external_trigger_input_in;
            tim_prev_reg            <= timer_trigger_input_in;
            if (start) begin
                seq_first_reg  <= fch_now;
                seq_factor_reg <= aas_factor(division_select);
                chan_reg       <= fch_now;
            end else if (conv_done) begin
                chan_reg <= last_done ? seq_first_reg : chan_reg + 3'h1;
            end
            if (conv_sample) begin
                sample_reg <= conv_value_in;
            end
        end
    end

    assign result.valid   = conv_done && conversion_running_flag;
    assign result.channel = chan_reg;
    assign result.value   = sample_reg;

    // ------------------------------------------------------------
    // Register writes and result storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            repeat_mode_reg      <= CTRL_RESET[CTRL_CONT_BIT];
            power_reg            <= CTRL_RESET[CTRL_POW_BIT];
            ext_en_reg           <= CTRL_RESET[CTRL_EXTEN_BIT];
            tim_en_reg           <= CTRL_RESET[CTRL_INTEN_BIT];
            first_channel_select <= CTRL_RESET[CTRL_FCH_LSB +: 3];
            division_select      <= PRESC_RESET;
            low6_reg             <= THR_LOW_RESET;
            low7_reg             <= THR_LOW_RESET;
            high6_reg            <= THR_HIGH_RESET;
            high7_reg            <= THR_HIGH_RESET;
            for (int i = 0; i < 8; i++) begin
                data_reg[i] <= 8'h00;
            end
        end else begin
            if (wr_ctrl) begin
                repeat_mode_reg      <= pwdata[CTRL_CONT_BIT];
                power_reg            <= pwdata[CTRL_POW_BIT];
                ext_en_reg           <= pwdata[CTRL_EXTEN_BIT];
                tim_en_reg           <= pwdata[CTRL_INTEN_BIT];
                first_channel_select <= pwdata[CTRL_FCH_LSB +: 3];
            end
            if (wr && paddr == ADDR_PRESC) begin
                division_select <= pwdata[2:0];
            end
            if (wr && paddr == ADDR_LT6) begin
                low6_reg <= pwdata[7:0];
            end
            if (wr && paddr == ADDR_LT7) begin
                low7_reg <= pwdata[7:0];
            end
            if (wr && paddr == ADDR_UT6) begin
                high6_reg <= pwdata[7:0];
            end
            if (wr && paddr == ADDR_UT7) begin
                high7_reg <= pwdata[7:0];
            end
            if (result.valid) begin
                data_reg[chan_reg] <= sample_reg;
            end else if (wr && sel_data) begin
                data_reg[paddr[4:2]] <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt control
    // ------------------------------------------------------------
    logic eos_set;
    assign eos_set = last_done && conversion_running_flag;

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            end_of_sequence_request <= 1'b0;
            window_alarm_request    <= 1'b0;
            eos_mask_reg            <= 1'b0;
            wdg_mask_reg            <= 1'b0;
            level_reg               <= 3'h0;
        end else begin
            // Hardware set wins over a software write in the same cycle
            end_of_sequence_request <= eos_set
                                    || (wr_int ? pwdata[INT_EOS_BIT] : end_of_sequence_request);
            window_alarm_request    <= alarm_hit
                                    || (wr_int ? pwdata[INT_WDG_BIT] : window_alarm_request);
            if (wr_int) begin
                eos_mask_reg <= pwdata[INT_EOSM_BIT];
                wdg_mask_reg <= pwdata[INT_WDGM_BIT];
                level_reg    <= pwdata[INT_PRI_LSB +: 3];
            end
        end
    end

    logic wdg_act;
    logic eos_act;
    assign wdg_act          = window_alarm_request && wdg_mask_reg;
    assign eos_act          = end_of_sequence_request && eos_mask_reg;
    assign irq_out          = (wdg_act || eos_act) && (level_reg != 3'h0);
    assign irq_is_alarm_out = wdg_act && irq_out;
    assign irq_level_out    = level_reg;

    assign mux_channel_out  = chan_reg;
    assign sample_hold_out  = conv_sample;
    assign power_up_out     = power_reg;

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    aas_timer u_timer (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .start_in   (timer_start),
        .abort_in   (abort),
        .factor_in  (seq_factor_reg),
        .sample_out (conv_sample),
        .done_out   (conv_done)
    );

    aas_watch u_watch (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .result_in  (result),
        .low6_in    (low6_reg),
        .low7_in    (low7_reg),
        .high6_in   (high6_reg),
        .high7_in   (high7_reg),
        .clear_in   (wdg_clear),
        .flags_out  (cmp_flags),
        .alarm_out  (alarm_hit)
    );
endmodule : aas_sequencer
`default_nettype wire

/* sim/aas_analog_model.sv */
`default_nettype none
module aas_analog_model
    import aas_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic [2:0] channel_in,
    input  wire logic       hold_in,
    output logic [7:0]      value_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] idle_q = 8'h5A;
    // Outside the hold phase: pattern flips every cycle so a late sample shows up
    always @(posedge clk_sys_in) idle_q <= ~idle_q;
    assign value_out = hold_in ? {1'b0, channel_in, 4'h5} : idle_q;
endmodule : aas_analog_model
`default_nettype wire

/* sim/aas_sequencer_props.sv */
`default_nettype none
module aas_sequencer_props
    import aas_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        rstn_in,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic [2:0]  mux_channel_out,
    input wire logic        sample_hold_out,
    input wire logic        power_up_out,
    input wire logic        irq_out,
    input wire logic        irq_is_alarm_out,
    input wire logic [2:0]  irq_level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    // Length of the current sampling phase so far
    logic [11:0] sh_cnt = 12'h000;
    always @(posedge clk_sys_in) sh_cnt <= sample_hold_out ? sh_cnt + 12'h001 : 12'h000;
    default disable iff (!rstn_in);
    property p_reset_quiet;
        disable iff (1'b0) !rstn_in |=> !irq_out && !sample_hold_out && !power_up_out;
    endproperty
    property p_power_gate;  !power_up_out |=> !sample_hold_out; endproperty
    property p_level;       irq_out |-> irq_level_out != 3'h0; endproperty
    property p_alarm_first; irq_is_alarm_out |-> irq_out; endproperty
    property p_sample_min;  $rose(sample_hold_out) |-> sample_hold_out[*8]; endproperty
    property p_sample_end;  sample_hold_out |-> sh_cnt < 12'(16 * SAMPLE_CYCLES); endproperty
    property p_data_width;  psel && !penable && !pwrite |=> prdata[31:8] == 24'h0; endproperty
    property p_chan_stable;
        sample_hold_out && $past(sample_hold_out) |-> $stable(mux_channel_out);
    endproperty
    a_reset_quiet:  assert property (p_reset_quiet)  else $error("outputs active in reset");
    a_power_gate:   assert property (p_power_gate)   else $error("sampling while off");
    a_level:        assert property (p_level)        else $error("request at level 0");
    a_alarm_first:  assert property (p_alarm_first)  else $error("alarm flag alone");
    a_sample_min:   assert property (p_sample_min)   else $error("sampling too short");
    a_sample_end:   assert property (p_sample_end)   else $error("sampling too long");
    a_data_width:   assert property (p_data_width)   else $error("upper read bits set");
    a_chan_stable:  assert property (p_chan_stable)  else $error("channel moved in sample");
    c_last_channel: cover property ($rose(sample_hold_out) && mux_channel_out == 3'h7);
    c_irq:          cover property ($rose(irq_out));
    c_alarm:        cover property ($rose(irq_is_alarm_out));
endmodule : aas_sequencer_props
bind aas_sequencer aas_sequencer_props u_aas_sequencer_props (.clk_sys_in, .rstn_in, .psel,
    .penable, .pwrite, .prdata, .mux_channel_out, .sample_hold_out, .power_up_out, .irq_out,
    .irq_is_alarm_out, .irq_level_out);
`default_nettype wire

/* sim/tb_aas_sequencer.sv */
`default_nettype none
module tb_aas_sequencer
    import aas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 0, rstn_in = 0, psel = 0, penable = 0, pwrite = 0, err, sh_d = 0;
    logic external_trigger_input_in = 0, timer_trigger_input_in = 0, pready, pslverr;
    logic sample_hold_out, power_up_out, irq_out, irq_is_alarm_out;
    logic [7:0]  paddr = 0, conv_value_in;
    logic [31:0] pwdata = 0, prdata, q;
    logic [2:0]  mux_channel_out, irq_level_out;
    logic [2:0]  chq[$];
    int errors = 0, n_compared = 0, cyc = 0, slen = 0, llen = 0, per = 0, t0 = 0, n, sz;
    aas_sequencer u_aas_sequencer (.clk_sys_in, .rstn_in, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .external_trigger_input_in, .timer_trigger_input_in,
        .conv_value_in, .mux_channel_out, .sample_hold_out, .power_up_out, .irq_out,
        .irq_is_alarm_out, .irq_level_out);
    aas_analog_model u_aas_analog_model (.clk_sys_in, .channel_in(mux_channel_out),
        .hold_in(sample_hold_out), .value_out(conv_value_in));
    initial forever #5 clk_sys_in = ~clk_sys_in;
    // ------------------------------------------------------------
    // Sample monitor and bus tasks
    // ------------------------------------------------------------
    always @(posedge clk_sys_in) begin
        cyc++;
        if (sample_hold_out && !sh_d) begin
            chq.push_back(mux_channel_out);
            per = cyc - t0;
            t0 = cyc;
        end
        if (sample_hold_out) slen++;
        else if (sh_d) begin
            llen = slen;
            slen = 0;
        end
        sh_d = sample_hold_out;
    end
    task automatic close_out;
        if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            k++;
        end while (pready !== 1'b1 && k < 16);
        q = prdata;
        err = pslverr;
        if (k >= 16) begin
            chk(1, 0);
            close_out();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_in);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    task automatic wait_idle;
        n = 0;
        do begin
            apb(1'b0, ADDR_CTRL, 32'h0);
            n++;
        end while (q[CTRL_RUN_BIT] !== 1'b0 && n < 500);
        if (n >= 500) begin
            chk(1, 0);
            close_out();
        end
    endtask : wait_idle
    task automatic single(input logic [2:0] first, input logic [2:0] pr, input int f);
        chq.delete();
        apb(1'b1, ADDR_INTCTL, 32'h1C);
        apb(1'b1, ADDR_PRESC, {29'h0, pr});
        apb(1'b1, ADDR_CTRL, {24'h0, first, 5'h05});
        wait_idle();
        chk(32'(chq.size()), 32'(8 - first));
        foreach (chq[i]) chk(32'(chq[i]), 32'(first + i));
        chk(32'(llen), 32'(84 * f));
        if (first < 7) chk(32'(per >= 138 * f && per <= 138 * f + 3), 1);
        for (int c = first; c < 8; c++) rd(8'(4 * c), 32'(c * 16 + 5));
        apb(1'b0, ADDR_INTCTL, 32'h0);
        chk(32'(q[INT_EOS_BIT]), 1);
    endtask : single
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_INTCTL, 32'h0);
        rd(ADDR_PRESC, 32'h7);
        rd(ADDR_UT7, 32'h0000_00FF);
        rd(8'h40, 32'h0);
        chk(32'(err), 1);
        apb(1'b1, ADDR_CTRL, 32'h01);
        rd(ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h04);
        chk(32'(power_up_out), 1);
        single(3'h3, 3'h7, 1);
        single(3'h7, 3'h6, 2);
        single(3'h7, 3'h4, 8);
        apb(1'b1, ADDR_LT6, 32'h70);
        apb(1'b1, ADDR_UT7, 32'h75);
        single(3'h6, 3'h7, 1);
        rd(ADDR_CMPRES, 32'h90);
        apb(1'b0, ADDR_INTCTL, 32'h0);
        chk(32'(q[INT_WDG_BIT]), 1);
        chk(32'({irq_out, irq_is_alarm_out, irq_level_out}), 32'h19);
        apb(1'b1, ADDR_INTCTL, 32'h1C);
        rd(ADDR_CMPRES, 32'h0);
        chk(32'({irq_out, irq_is_alarm_out, irq_level_out}), 32'h01);
        apb(1'b1, ADDR_CTRL, 32'hFC);
        for (int k = 0; k < 2; k++) begin
            chq.delete();
            repeat (2) begin
                {timer_trigger_input_in, external_trigger_input_in} <= 2'(k + 1);
                repeat (20) @(posedge clk_sys_in);
                {timer_trigger_input_in, external_trigger_input_in} <= 2'b00;
                repeat (20) @(posedge clk_sys_in);
            end
            wait_idle();
            chk(32'(chq.size()), 1);
        end
        chq.delete();
        apb(1'b1, ADDR_CTRL, 32'hCF);
        n = 0;
        while ((chq.size() < 5 || sample_hold_out) && n < 3000) begin
            @(posedge clk_sys_in);
            n++;
        end
        if (n >= 3000) begin
            chk(1, 0);
            close_out();
        end
        apb(1'b1, ADDR_CTRL, 32'h04);
        sz = chq.size();
        for (int i = 0; i < 5; i++) chk(32'(chq[i]), 32'(6 + i % 2));
        repeat (300) @(posedge clk_sys_in);
        chk(32'(chq.size()), 32'(sz));
        close_out();
    end
endmodule : tb_aas_sequencer
`default_nettype wire
